/* design/fg_pkg.sv */
// constants, register map and bus states for the field-timed gpi/gpo block
// assumes a single 200 MHz clock and field/frame ticks from video timing
package fg_pkg;

	// ------------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------------
	localparam int         GPI_MAX   = 16;
	localparam int         GPO_MAX   = 128;
	localparam int         PULSE_W   = 8;
	localparam int         CFG_W     = 10;
	localparam int         CLK_MHZ   = 200;

	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_EDGE     = 8'h04;
	localparam logic [7:0] OFS_STATE    = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFS_GPO_SEL  = 8'h14;
	localparam logic [7:0] OFS_GPO_CFG  = 8'h18;
	localparam logic [7:0] OFS_GPO_TRIG = 8'h1C;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int         CTRL_EN_BIT    = 0;
	localparam int         EDGE_RISE_BIT  = 0;
	localparam int         EDGE_FALL_BIT  = 1;
	localparam int         CFG_LEN_LSB    = 0;
	localparam int         CFG_SHAPE_BIT  = 8;
	localparam int         CFG_IDLE_BIT   = 9;
	localparam int         TRIG_CH_LSB    = 0;
	localparam int         TRIG_LEVEL_BIT = 8;
	localparam int         IRQ_DONE_BIT   = 16;

	// ------------------------------------------------------------------
	// reset values and codes
	// ------------------------------------------------------------------
	localparam logic       CTRL_EN_RST  = 1'h1;
	localparam logic [1:0] EDGE_CODE_RST = 2'h1;
	localparam logic [7:0] PULSE_LAST   = 8'h01;
	localparam logic [7:0] PULSE_NONE   = 8'h00;

	typedef enum logic [1:0] {
		FG_BUS_IDLE = 2'b00,
		FG_BUS_MEM  = 2'b01,
		FG_BUS_DONE = 2'b10
	} fg_bus_t;

	// edge hit for one input: sel bit0 rising, bit1 falling, both allowed
	function automatic logic fg_edge_hit(input logic       prev,
	                                     input logic       cur,
	                                     input logic [1:0] sel);
		fg_edge_hit = (sel[EDGE_RISE_BIT] & ~prev & cur) |
		              (sel[EDGE_FALL_BIT] & prev & ~cur);
	endfunction

endpackage

/* design/fg_cfg_mem.sv */
// per-channel output configuration store, one word per channel
// assumes one port: a write and a registered read never in one cycle
module fg_cfg_mem #(
	parameter int DEPTH = 128,
	parameter int WIDTH = 10,
	parameter int AW    = 7
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// access port
	input  wire logic             we,
	input  wire logic             re,
	input  wire logic [AW-1:0]    addr,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	// storage array carries no reset so it maps onto ram cells
	always_ff @(posedge clk) begin
		if (ce && we) begin
			mem[addr] <= wdata;
		end
	end

	// read data always comes out of a register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (ce && re) begin
			rdata <= mem[addr];
		end
	end

endmodule

/* design/fg_gpio.sv */
// field-timed trigger inputs and contact-closure outputs with apb registers
// assumes field_tick and frame_tick are one-cycle pulses on clk; gpi_pin
// comes from opto-couplers (high = current flows) and is asynchronous
//
// Function
// - each input fires on rising, falling or both edges, chosen per input.
// - sixteen inputs, each with its own edge selection field.
// - input active while opto current flows, inactive otherwise.
// - rising is inactive to active; falling is active to inactive.
// - up to 128 output channels, each with its own properties.
// - each output is either pulsed or static level.
// - each output rests open or closed when not triggered.
// - pulse length is a whole number of frames, at most 255.
//
// Chosen here: the address map and the APB register port.
module fg_gpio
	import fg_pkg::*;
#(
	parameter int NUM_GPI = 16,
	parameter int NUM_GPO = 128
) (
	// clock, reset, enable
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               ce,
	// apb slave
	input  wire logic [7:0]         paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// video timing
	input  wire logic               field_tick,
	input  wire logic               frame_tick,
	// contacts
	input  wire logic [NUM_GPI-1:0] gpi_pin,
	output logic      [NUM_GPI-1:0] gpi_event,
	output logic      [NUM_GPO-1:0] gpo_close,
	// interrupt
	output logic                    irq
);

	localparam int CH_W = $clog2(NUM_GPO);

	// ------------------------------------------------------------------
	// parameter checks
	// ------------------------------------------------------------------
	if (NUM_GPI < 1 || NUM_GPI > GPI_MAX) begin : g_bad_gpi
		$error("NUM_GPI out of range");
	end
	if (NUM_GPO < 2 || NUM_GPO > GPO_MAX) begin : g_bad_gpo
		$error("NUM_GPO out of range");
	end

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic [NUM_GPI-1:0]   gpi_meta;
	logic [NUM_GPI-1:0]   gpi_sync;
	logic [NUM_GPI-1:0]   gpi_samp;
	logic                 ctrl_en;
	logic [2*NUM_GPI-1:0] gpi_edge;
	logic [IRQ_DONE_BIT:0] irq_stat;
	logic [IRQ_DONE_BIT:0] irq_mask;
	logic [IRQ_DONE_BIT:0] next_set;
	logic [CH_W-1:0]      gpo_sel;
	logic [NUM_GPO-1:0]   gpo_active;
	logic [NUM_GPO-1:0]   idle_bits;
	logic [NUM_GPO-1:0]   pulse_bits;
	logic [PULSE_W-1:0]   cnt [NUM_GPO];
	fg_bus_t              bus_state;
	logic                 init_busy;
	logic [CH_W-1:0]      init_addr;
	logic                 acc_start;
	logic                 acc_done;
	logic                 is_mem;
	logic                 mapped;
	logic [31:0]          rd_value;
	logic                 cfg_wr;
	logic                 trig_fire;
	logic [CH_W-1:0]      trig_ch;
	logic                 trig_level;
	logic [PULSE_W-1:0]   trig_len;
	logic                 mem_we;
	logic                 mem_re;
	logic [CH_W-1:0]      mem_addr;
	logic [CFG_W-1:0]     mem_wdata;
	logic [CFG_W-1:0]     mem_rdata;

	// channel index lies inside the populated outputs
	function automatic logic ch_ok(input logic [CH_W-1:0] ch);
		ch_ok = int'(ch) < NUM_GPO;
	endfunction

	// ------------------------------------------------------------------
	// input path
	// ------------------------------------------------------------------
	// two-stage synchroniser; only the second stage feeds logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gpi_meta <= '0;
			gpi_sync <= '0;
		end else if (ce) begin
			gpi_meta <= gpi_pin;
			gpi_sync <= gpi_meta;
		end
	end

	// sampling once per field rejects bounce and assumes closures last
	// at least a field, otherwise a short closure can be missed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gpi_samp  <= '0;
			gpi_event <= '0;
		end else if (ce) begin
			if (field_tick) begin
				gpi_samp <= gpi_sync;
				for (int i = 0; i < NUM_GPI; i++) begin
					gpi_event[i] <= ctrl_en & fg_edge_hit(gpi_samp[i],
						gpi_sync[i], gpi_edge[2*i +: 2]);
				end
			end else begin
				gpi_event <= '0;
			end
		end
	end

	// ------------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------------
	// config reads, config writes and trigger writes go through a memory lookup first
	assign acc_start = psel && penable && !pready && !init_busy &&
	                   bus_state == FG_BUS_IDLE;
	assign acc_done  = psel && penable && pready;
	assign is_mem    = paddr == OFS_GPO_CFG ||
	                   (paddr == OFS_GPO_TRIG && pwrite);
	assign cfg_wr    = acc_done && pwrite && paddr == OFS_GPO_CFG &&
	                   ch_ok(gpo_sel);
	assign trig_ch   = pwdata[TRIG_CH_LSB +: CH_W];
	assign trig_level = pwdata[TRIG_LEVEL_BIT];
	assign trig_len  = mem_rdata[CFG_LEN_LSB +: PULSE_W];
	assign trig_fire = acc_done && pwrite && paddr == OFS_GPO_TRIG &&
	                   ch_ok(trig_ch);

	// read mux for every register; the config word comes from the memory read
	always_comb begin
		mapped   = 1'b1;
		rd_value = '0;
		case (paddr)
			OFS_CTRL:     rd_value[CTRL_EN_BIT] = ctrl_en;
			OFS_EDGE:     rd_value = 32'(gpi_edge);
			OFS_STATE:    rd_value = 32'(gpi_samp);
			OFS_IRQ_STAT: rd_value = 32'(irq_stat);
			OFS_IRQ_MASK: rd_value = 32'(irq_mask);
			OFS_GPO_SEL:  rd_value = 32'(gpo_sel);
			OFS_GPO_CFG:  rd_value = 32'(mem_rdata);
			OFS_GPO_TRIG: rd_value = '0;
			default:      mapped = 1'b0;
		endcase
	end

	// handshake: one wait state, two when the memory is consulted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_state <= FG_BUS_IDLE;
			pready    <= 1'b0;
			prdata    <= '0;
			pslverr   <= 1'b0;
		end else if (ce) begin
			case (bus_state)
				FG_BUS_IDLE: begin
					if (acc_start && is_mem) begin
						bus_state <= FG_BUS_MEM;
					end else if (acc_start) begin
						bus_state <= FG_BUS_DONE;
						pready    <= 1'b1;
						prdata    <= pwrite ? '0 : rd_value;
						pslverr   <= !mapped;
					end
				end
				FG_BUS_MEM: begin
					bus_state <= FG_BUS_DONE;
					pready    <= 1'b1;
					prdata    <= pwrite ? '0 : rd_value;
					pslverr   <= 1'b0;
				end
				FG_BUS_DONE: begin
					bus_state <= FG_BUS_IDLE;
					pready    <= 1'b0;
					prdata    <= '0;
					pslverr   <= 1'b0;
				end
				default: begin
					bus_state <= FG_BUS_IDLE;
					pready    <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------
	// writes land on the edge that completes the transfer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_en  <= CTRL_EN_RST;
			gpi_edge <= {NUM_GPI{EDGE_CODE_RST}};
			irq_mask <= '0;
			gpo_sel  <= '0;
		end else if (ce && acc_done && pwrite) begin
			case (paddr)
				OFS_CTRL:     ctrl_en  <= pwdata[CTRL_EN_BIT];
				OFS_EDGE:     gpi_edge <= pwdata[2*NUM_GPI-1:0];
				OFS_IRQ_MASK: irq_mask <= pwdata[IRQ_DONE_BIT:0];
				OFS_GPO_SEL:  gpo_sel  <= pwdata[CH_W-1:0];
				default:      ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------------
	// a new event in the clearing cycle survives: set beats clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat <= '0;
			irq      <= 1'b0;
		end else if (ce) begin
			if (acc_done && pwrite && paddr == OFS_IRQ_STAT) begin
				irq_stat <= (irq_stat & ~pwdata[IRQ_DONE_BIT:0]) | next_set;
			end else begin
				irq_stat <= irq_stat | next_set;
			end
			irq <= |(irq_stat & irq_mask);
		end
	end

	// ------------------------------------------------------------------
	// configuration memory and its power-up clear
	// ------------------------------------------------------------------
	// the sweep zeroes every channel so lengths are never random
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			init_busy <= 1'b1;
			init_addr <= '0;
		end else if (ce && init_busy) begin
			init_addr <= init_addr + 1'b1;
			if (int'(init_addr) == NUM_GPO - 1) begin
				init_busy <= 1'b0;
			end
		end
	end

	assign mem_we    = init_busy || cfg_wr;
	assign mem_re    = acc_start && is_mem;
	assign mem_addr  = init_busy ? init_addr :
	                   (paddr == OFS_GPO_TRIG ? trig_ch : gpo_sel);
	assign mem_wdata = init_busy ? '0 : pwdata[CFG_W-1:0];

	fg_cfg_mem #(
		.DEPTH (NUM_GPO),
		.WIDTH (CFG_W),
		.AW    (CH_W)
	) u_cfg (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.we    (mem_we),
		.re    (mem_re),
		.addr  (mem_addr),
		.wdata (mem_wdata),
		.rdata (mem_rdata)
	);

	// ------------------------------------------------------------------
	// output channels
	// ------------------------------------------------------------------
	// shape and idle state mirrored in flops so all outputs run at once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_bits  <= '0;
			pulse_bits <= '0;
		end else if (ce && cfg_wr) begin
			idle_bits[gpo_sel]  <= pwdata[CFG_IDLE_BIT];
			pulse_bits[gpo_sel] <= pwdata[CFG_SHAPE_BIT];
		end
	end

	// pulse ends raise the done event
	always_comb begin
		next_set = '0;
		next_set[NUM_GPI-1:0] = gpi_event;
		for (int i = 0; i < NUM_GPO; i++) begin
			if (frame_tick && pulse_bits[i] && gpo_active[i] &&
			    cnt[i] <= PULSE_LAST &&
			    !(trig_fire && trig_ch == CH_W'(i))) begin
				next_set[IRQ_DONE_BIT] = 1'b1;
			end
		end
	end

	// pulses count whole frame ticks; a retrigger restarts the count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gpo_active <= '0;
			for (int i = 0; i < NUM_GPO; i++) begin
				cnt[i] <= PULSE_NONE;
			end
		end else if (ce) begin
			for (int i = 0; i < NUM_GPO; i++) begin
				if (cfg_wr && gpo_sel == CH_W'(i)) begin
					gpo_active[i] <= 1'b0;
					cnt[i]        <= PULSE_NONE;
				end else if (trig_fire && trig_ch == CH_W'(i)) begin
					if (pulse_bits[i]) begin
						gpo_active[i] <= trig_len != PULSE_NONE;
						cnt[i]        <= trig_len;
					end else begin
						gpo_active[i] <= trig_level;
					end
				end else if (frame_tick && pulse_bits[i] && gpo_active[i]) begin
					if (cnt[i] <= PULSE_LAST) begin
						gpo_active[i] <= 1'b0;
						cnt[i]        <= PULSE_NONE;
					end else begin
						cnt[i] <= cnt[i] - PULSE_LAST;
					end
				end
			end
		end
	end

	// contact closed when exactly one of idle-closed and active holds
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gpo_close <= '0;
		end else if (ce) begin
			gpo_close <= gpo_active ^ idle_bits;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// edge checks watch input 1 (rise), input 2 (fall) and input 0 (off), channel
	// checks watch output 1 (pulse) and output 0 (static)
	a_rise_event: assert property (ce && field_tick && ctrl_en &&
		gpi_edge[2+EDGE_RISE_BIT] && gpi_sync[1] && !gpi_samp[1]
		|=> gpi_event[1])
		else $error("rising edge not reported");
	a_fall_event: assert property (ce && field_tick && ctrl_en &&
		gpi_edge[4+EDGE_FALL_BIT] && !gpi_sync[2] && gpi_samp[2]
		|=> gpi_event[2])
		else $error("falling edge not reported");
	a_edge_off: assert property (ce && field_tick &&
		gpi_edge[1:0] == 2'h0 |=> !gpi_event[0])
		else $error("event with edge selection off");
	a_state_follow: assert property (ce && field_tick
		|=> gpi_samp == $past(gpi_sync))
		else $error("input state not sampled at field");
	a_idle_rest: assert property (ce && !gpo_active[0]
		|=> gpo_close[0] == $past(idle_bits[0]))
		else $error("idle output not at rest state");
	a_pulse_start: assert property (ce && trig_fire &&
		trig_ch == CH_W'(1) && pulse_bits[1] && trig_len != PULSE_NONE
		|=> gpo_active[1] && cnt[1] == $past(trig_len))
		else $error("pulse did not start with its length");
	a_pulse_end: assert property (ce && frame_tick && !trig_fire &&
		!cfg_wr && pulse_bits[1] && gpo_active[1] && cnt[1] == PULSE_LAST
		|=> !gpo_active[1] ##1 gpo_close[1] == idle_bits[1])
		else $error("pulse did not end on last frame");
	a_static_hold: assert property (ce && frame_tick &&
		!pulse_bits[0] && !trig_fire && !cfg_wr |=> $stable(gpo_active[0]))
		else $error("static output moved on frame tick");
	a_apb_answer: assert property (acc_start && !is_mem && ce
		|=> pready && !$past(pready))
		else $error("register access not answered");

	c_rise_seen: cover property (gpi_event[0]);
	c_pulse_run: cover property (trig_fire && pulse_bits[trig_ch]);
	c_pulse_done: cover property (next_set[IRQ_DONE_BIT] && ce);
	c_static_set: cover property (trig_fire && !pulse_bits[trig_ch]);

endmodule

/* verif/fg_equip.sv */
// customer equipment model: relay contacts feeding the opto inputs
// assumes field_tick comes from the bench video timing on clk
module fg_equip (
	// timing
	input  wire logic        clk,
	input  wire logic        field_tick,
	// contacts, high while loop current flows
	output logic      [15:0] gpi_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] last_pin;
	int          held;

	initial begin
		gpi_pin = 16'h0000;
		last_pin = 16'h0000;
		held = 1;
	end

	// fields seen since the contacts last moved
	always @(posedge clk) begin
		if (gpi_pin !== last_pin)
			held <= 0;
		else if (field_tick)
			held <= held + 1;
		last_pin <= gpi_pin;
	end

	// a shorter closure may vanish between field samples, so never send one
	// no private limit here: the bench watchdog ends a hang
	task automatic apply(input logic [15:0] v);
		while (held < 1) begin
			@(posedge clk);
		end
		@(posedge clk);
		gpi_pin <= v;
	endtask
endmodule

/* verif/test_fg_gpio.sv */
// self-checking bench for the field-timed gpi/gpo block
// assumes the bench makes field/frame ticks and owns the apb master
module test_fg_gpio
	import fg_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [31:0] EDGE_MIX = 32'hE4E4E4E4; // off,rise,fall,both

	logic         clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
	logic         field_tick, frame_tick, err;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rd, stat, mask;
	logic [15:0]  gpi_pin, gpi_event, lfsr, pin_prev, ev;
	logic [15:0]  ev_q[$];
	logic [127:0] gpo_close, exp_gpo;
	int           num_errors, compares;
	int           g_ch[5]   = '{1, 127, 64, 0, 90};
	int           g_len[5]  = '{2, 255, 0, 7, 1};
	logic         g_pul[5]  = '{1, 1, 1, 0, 0};
	logic         g_idle[5] = '{0, 1, 1, 1, 0};

	fg_gpio #(.NUM_GPI(16), .NUM_GPO(128)) dut (
		.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .field_tick(field_tick),
		.frame_tick(frame_tick), .gpi_pin(gpi_pin),
		.gpi_event(gpi_event), .gpo_close(gpo_close), .irq(irq)
	);

	fg_equip u_eq (.clk(clk), .field_tick(field_tick), .gpi_pin(gpi_pin));

	// 200 mhz clock
	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// waits as long as the slave needs (config sweep included); a hang
	// is ended by the watchdog, not here
	task automatic apb(input logic w, input logic [7:0] a,
	                   input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		check(128'(rd), 128'(exp));
	endtask

	// one-cycle tick; returns in the cycle the design answers it
	task automatic tick(input logic fld);
		@(posedge clk);
		if (fld)
			field_tick <= 1'b1;
		else
			frame_tick <= 1'b1;
		@(posedge clk);
		field_tick <= 1'b0;
		frame_tick <= 1'b0;
		#1;
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic gpi_step(input logic [15:0] v, input logic en);
		u_eq.apply(v);
		repeat (3) @(posedge clk);
		tick(1'b1);
		for (int i = 0; i < 16; i++)
			ev[i] = en & ((EDGE_MIX[2*i] & ~pin_prev[i] & v[i]) |
			              (EDGE_MIX[2*i+1] & pin_prev[i] & ~v[i]));
		ev_q.push_back(ev);
		check(128'(gpi_event), 128'(ev_q.pop_front()));
		stat = stat | 32'(ev);
		// state follows the contacts even while events are disabled
		rdc(OFS_STATE, 32'(v));
		pin_prev = v;
		rdc(OFS_IRQ_STAT, stat);
		check(128'(irq), 128'(|(stat & mask)));
	endtask

	task automatic gpo_case(input int ch, input logic pul, input logic idl,
	                        input int len);
		logic [31:0] cfg;
		cfg = {22'h000000, idl, pul, 8'(len)};
		apb(1'b1, OFS_GPO_SEL, 32'(ch));
		apb(1'b1, OFS_GPO_CFG, cfg);
		rdc(OFS_GPO_CFG, cfg);
		exp_gpo[ch] = idl;
		check(gpo_close, exp_gpo);
		if (pul) begin
			apb(1'b1, OFS_GPO_TRIG, 32'(ch));
			settle();
			exp_gpo[ch] = (len != 0) ? ~idl : idl;
			check(gpo_close, exp_gpo);
			for (int k = 1; k <= len; k++) begin
				tick(1'b0);
				if (k == len) begin
					settle();
					exp_gpo[ch] = idl;
					stat[IRQ_DONE_BIT] = 1'b1;
				end
				check(gpo_close, exp_gpo);
			end
		end else begin
			for (int s = 1; s >= 0; s--) begin
				apb(1'b1, OFS_GPO_TRIG, {23'h000000, s[0], 1'b0, ch[6:0]});
				settle();
				exp_gpo[ch] = s[0] ? ~idl : idl;
				check(gpo_close, exp_gpo);
			end
		end
	endtask

	task automatic finish_test();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		{rst_n, psel, penable, pwrite, field_tick, frame_tick} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		{num_errors, compares} = 0;
		lfsr = 16'h0042;
		{stat, mask, pin_prev, exp_gpo} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rdc(OFS_CTRL, 32'h00000001);
		rdc(OFS_EDGE, 32'h55555555);
		rdc(OFS_IRQ_MASK, 32'h00000000);
		rdc(OFS_GPO_TRIG, 32'h00000000);
		check(gpo_close, exp_gpo);
		apb(1'b0, 8'h20, 32'h00000000);
		check(128'({err, rd}), 128'({1'b1, 32'h00000000}));
		apb(1'b1, OFS_EDGE, EDGE_MIX);
		rdc(OFS_EDGE, EDGE_MIX);
		lfsr = lfsr_next(lfsr);
		mask = {15'h0000, 1'b1, lfsr};
		apb(1'b1, OFS_IRQ_MASK, mask);
		// random contact patterns, then one field with no movement
		for (int k = 0; k < 12; k++) begin
			lfsr = lfsr_next(lfsr);
			gpi_step(lfsr, 1'b1);
		end
		gpi_step(pin_prev, 1'b1);
		lfsr = lfsr_next(lfsr);
		apb(1'b1, OFS_IRQ_STAT, 32'(lfsr));
		stat = stat & ~32'(lfsr);
		rdc(OFS_IRQ_STAT, stat);
		check(128'(irq), 128'(|(stat & mask)));
		// inputs disabled: contacts move but nothing fires
		apb(1'b1, OFS_CTRL, 32'h00000000);
		gpi_step(~pin_prev, 1'b0);
		for (int c = 0; c < 5; c++)
			gpo_case(g_ch[c], g_pul[c], g_idle[c], g_len[c]);
		rdc(OFS_IRQ_STAT, stat);
		check(128'(irq), 128'(|(stat & mask)));
		finish_test();
	end

	// a hung handshake ends the run the same way
	initial begin
		#100000;
		num_errors++;
		finish_test();
	end
endmodule
